// ---- src/wut_pkg.sv ----
// shared constants and types for the waveform update timing block
package wut_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int          SAMPLE_W   = 16;
	localparam int          NUM_CHAN   = 2;
	localparam int          QUEUE_DEP  = 16;
	localparam int          QPTR_W     = 4;
	localparam int          CNT_W      = 32;
	localparam logic [15:0] DIV_RESET  = 16'h0009;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
	localparam logic [7:0] OFS_DIV      = 8'h14;
	localparam logic [7:0] OFS_COUNT    = 8'h18;
	localparam logic [7:0] OFS_DATA     = 8'h1C;
	localparam logic [7:0] OFS_CMD      = 8'h20;
	localparam logic [7:0] OFS_DONE_CNT = 8'h24;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int BIT_FINITE     = 0;
	localparam int BIT_REGEN      = 1;
	localparam int BIT_PIN5_OUT   = 2;
	localparam int BIT_PIN6_OUT   = 3;
	localparam int BIT_TRIG_EN    = 4;
	localparam int BIT_REF_EXT    = 5;
	localparam int BIT_HOLD_EN    = 6;
	localparam int BIT_HOLD_POL   = 7;
	// command fields
	localparam int BIT_CMD_START  = 0;
	localparam int BIT_CMD_STOP   = 1;
	localparam int BIT_CMD_FLUSH  = 2;
	// interrupt fields
	localparam int IRQ_UNDERFLOW  = 0;
	localparam int IRQ_DONE       = 1;
	localparam int IRQ_STARTED    = 2;
	localparam int IRQ_W          = 3;

	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_RUN
	} wut_state_t;

	// one sample word: two channel codes packed together
	typedef struct packed {
		logic [SAMPLE_W-1:0] chan1;
		logic [SAMPLE_W-1:0] chan0;
	} wut_sample_t;

	// converter-side bundle
	typedef struct packed {
		wut_sample_t code;
		logic        ref_ext;
	} wut_dac_t;

endpackage

// ---- src/wut_core.sv ----
// waveform update timing: sample queue, update strobe, triggers, bus slave
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module wut_core (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   resetn_i,
	// axi4-lite write address and data
	input  wire logic [7:0]             s_axi_awaddr_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	output logic [1:0]                  s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	// axi4-lite read
	input  wire logic [7:0]             s_axi_araddr_i,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	// programmable pins, enable low while driven
	input  wire logic                   prog_pin_five_i,
	output logic                        prog_pin_five_o,
	output logic                        prog_pin_five_oe_n_o,
	input  wire logic                   prog_pin_six_i,
	output logic                        prog_pin_six_o,
	output logic                        prog_pin_six_oe_n_o,
	// hold trigger input
	input  wire logic                   generation_hold_trigger_i,
	// converter side
	output wut_pkg::wut_dac_t           dac_o,
	output logic                        dac_load_o,
	// interrupt
	output logic                        irq_o
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]                  ctrl;
	logic [15:0]                 div_load;
	logic [wut_pkg::CNT_W-1:0]   sample_goal;
	logic [wut_pkg::CNT_W-1:0]   sample_done;
	logic [wut_pkg::IRQ_W-1:0]   irq_stat;
	logic [wut_pkg::IRQ_W-1:0]   irq_en;
	wut_pkg::wut_sample_t        queue [wut_pkg::QUEUE_DEP];
	logic [wut_pkg::QPTR_W-1:0]  wr_ptr;
	logic [wut_pkg::QPTR_W-1:0]  rd_ptr;
	logic [wut_pkg::QPTR_W:0]    fill;
	wut_pkg::wut_state_t         state;
	logic [15:0]                 div_cnt;
	logic                        strobe_lvl;
	logic                        trig_lvl;
	logic                        pin6_q;
	logic                        aw_hold;
	logic                        w_hold;
	logic [7:0]                  aw_addr;
	logic [31:0]                 w_data;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	logic wr_go;
	logic rd_go;
	logic [31:0] cmd;
	logic queue_push;
	logic queue_empty;
	logic queue_full;
	logic tick;
	logic hold_act;
	logic trig_edge;
	logic start_now;
	logic stop_now;
	logic flush_now;
	logic underflow_ev;
	logic done_ev;
	logic regen;

	assign wr_go       = aw_hold && w_hold && !s_axi_bvalid_o;
	assign rd_go       = s_axi_arvalid_i && s_axi_arready_o;
	assign cmd         = (wr_go && hit(aw_addr, wut_pkg::OFS_CMD)) ?
		w_data : 32'h0000_0000;
	assign queue_empty = (fill == 5'h00);
	assign queue_full  = (fill == 5'h10);
	// pushes into a full queue are dropped; host watches the fill level
	assign queue_push  = wr_go && hit(aw_addr, wut_pkg::OFS_DATA) &&
		!queue_full && (state == wut_pkg::ST_IDLE || !regen);
	assign regen       = ctrl[wut_pkg::BIT_REGEN];
	assign flush_now   = cmd[wut_pkg::BIT_CMD_FLUSH];
	assign stop_now    = cmd[wut_pkg::BIT_CMD_STOP];

	// hold trigger masks the strobe; polarity is selectable
	assign hold_act = ctrl[wut_pkg::BIT_HOLD_EN] &&
		(generation_hold_trigger_i ^ ctrl[wut_pkg::BIT_HOLD_POL]);

	// rising edge on pin six input is the begin trigger
	assign trig_edge = prog_pin_six_i && !pin6_q &&
		!ctrl[wut_pkg::BIT_PIN6_OUT];
	assign start_now = (state == wut_pkg::ST_ARMED) &&
		(ctrl[wut_pkg::BIT_TRIG_EN] ? trig_edge : 1'b1);

	// strobe tick: divider wraps while running and not held
	assign tick = (state == wut_pkg::ST_RUN) && (div_cnt == 16'h0000) &&
		!hold_act;
	assign underflow_ev = tick && queue_empty && !regen;
	assign done_ev = tick && ctrl[wut_pkg::BIT_FINITE] &&
		(sample_done + 32'h1 >= sample_goal);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	// address and data are caught in either order, answer after both
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= wut_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata_i;
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (aw_addr[1:0] == 2'h0 &&
					aw_addr <= wut_pkg::OFS_DONE_CNT) ?
					wut_pkg::RESP_OKAY : wut_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_hold && !s_axi_bvalid_o;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// byte strobes ignored; every register is written whole
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl        <= wut_pkg::CTRL_RESET;
			div_load    <= wut_pkg::DIV_RESET;
			sample_goal <= 32'h0000_0000;
			irq_en      <= 3'h0;
		end else if (wr_go) begin
			if (hit(aw_addr, wut_pkg::OFS_CTRL))
				ctrl <= w_data[7:0];
			if (hit(aw_addr, wut_pkg::OFS_DIV))
				div_load <= w_data[15:0];
			if (hit(aw_addr, wut_pkg::OFS_COUNT))
				sample_goal <= w_data;
			if (hit(aw_addr, wut_pkg::OFS_IRQ_EN))
				irq_en <= w_data[2:0];
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= wut_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= wut_pkg::RESP_OKAY;
			unique case (s_axi_araddr_i)
				wut_pkg::OFS_CTRL:     s_axi_rdata_o <= {24'h0, ctrl};
				wut_pkg::OFS_STATUS:   s_axi_rdata_o <= {24'h0,
					state == wut_pkg::ST_RUN, state == wut_pkg::ST_ARMED,
					queue_full, fill};
				wut_pkg::OFS_IRQ_STAT: s_axi_rdata_o <= {29'h0, irq_stat};
				wut_pkg::OFS_IRQ_EN:   s_axi_rdata_o <= {29'h0, irq_en};
				wut_pkg::OFS_DIV:      s_axi_rdata_o <= {16'h0, div_load};
				wut_pkg::OFS_COUNT:    s_axi_rdata_o <= sample_goal;
				wut_pkg::OFS_DONE_CNT: s_axi_rdata_o <= sample_done;
				wut_pkg::OFS_IRQ_CLR, wut_pkg::OFS_DATA,
				wut_pkg::OFS_CMD:      s_axi_rdata_o <= 32'h0000_0000;
				default: begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= wut_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// generation sequencer
	// ------------------------------------------------------------
	// start arms; trigger or software start moves to run
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= wut_pkg::ST_IDLE;
		end else if (stop_now || done_ev) begin
			state <= wut_pkg::ST_IDLE;
		end else begin
			unique case (state)
				wut_pkg::ST_IDLE:
					if (cmd[wut_pkg::BIT_CMD_START])
						state <= wut_pkg::ST_ARMED;
				wut_pkg::ST_ARMED:
					if (start_now)
						state <= wut_pkg::ST_RUN;
				wut_pkg::ST_RUN:
					state <= wut_pkg::ST_RUN;
			endcase
		end
	end

	// pin six sampler for edge detection
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			pin6_q <= 1'b0;
		else
			pin6_q <= prog_pin_six_i;
	end

	// update strobe divider; period is div_load+1 system clocks
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt <= 16'h0000;
		end else if (state != wut_pkg::ST_RUN) begin
			div_cnt <= 16'h0000;
		end else if (!hold_act) begin
			div_cnt <= (div_cnt == 16'h0000) ? div_load : div_cnt - 16'h1;
		end
	end

	// strobe high for one clock with each tick, so every sample,
	// the first included, gets a falling edge; a divider of zero
	// keeps it high, so pin five then falls only when the ticks stop
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			strobe_lvl <= 1'b0;
		else
			strobe_lvl <= tick;
	end

	// begin trigger pulses high for one clock at the run entry
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			trig_lvl <= 1'b0;
		else
			trig_lvl <= start_now;
	end

	// ------------------------------------------------------------
	// sample queue
	// ------------------------------------------------------------
	// regenerate mode re-reads the same points; pointer wraps back to
	// the oldest stored point, which need not sit at index zero
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			fill   <= 5'h00;
		end else if (flush_now) begin
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			fill   <= 5'h00;
		end else if (regen) begin
			if (queue_push) begin
				wr_ptr <= wr_ptr + 4'h1;
				fill   <= fill + 5'h01;
			end
			if (tick && !queue_empty)
				rd_ptr <= (rd_ptr + 4'h1 == wr_ptr) ?
					wr_ptr - fill[wut_pkg::QPTR_W-1:0] : rd_ptr + 4'h1;
		end else begin
			if (queue_push)
				wr_ptr <= wr_ptr + 4'h1;
			if (tick && !queue_empty)
				rd_ptr <= rd_ptr + 4'h1;
			fill <= fill + {4'h0, queue_push} -
				{4'h0, tick && !queue_empty};
		end
	end

	// storage write, one word per push
	always_ff @(posedge clk_sys_i) begin
		if (queue_push)
			queue[wr_ptr] <= w_data;
	end

	// ------------------------------------------------------------
	// converter output
	// ------------------------------------------------------------
	// both channels load together on the same strobe
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dac_o      <= '0;
			dac_load_o <= 1'b0;
		end else begin
			dac_load_o      <= tick && !queue_empty;
			dac_o.ref_ext   <= ctrl[wut_pkg::BIT_REF_EXT];
			if (tick && !queue_empty)
				dac_o.code <= queue[rd_ptr];
		end
	end

	// update strobe ticks since run start, empty-queue ticks included, for finite mode
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			sample_done <= 32'h0000_0000;
		else if (start_now)
			sample_done <= 32'h0000_0000;
		else if (tick)
			sample_done <= sample_done + 32'h1;
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	assign prog_pin_five_o      = strobe_lvl;
	assign prog_pin_five_oe_n_o = !ctrl[wut_pkg::BIT_PIN5_OUT];
	assign prog_pin_six_o       = trig_lvl;
	assign prog_pin_six_oe_n_o  = !ctrl[wut_pkg::BIT_PIN6_OUT];

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	// set wins over a clear landing in the same cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat &
				~((wr_go && hit(aw_addr, wut_pkg::OFS_IRQ_CLR)) ?
				w_data[2:0] : 3'h0)) |
				{start_now, done_ev, underflow_ev};
		end
	end

	assign irq_o = |(irq_stat & irq_en);

	// keep unused input bits referenced
	logic unused_bits;
	assign unused_bits = &{1'b0, s_axi_wstrb_i, prog_pin_five_i,
		cmd[31:3], w_data[31:8]};

endmodule

// ---- dv/wut_core_monitor.sv ----
// port checker for the waveform update timing block
`timescale 1ns/1ps
module wut_core_monitor (
	// clock and reset
	input wire logic              clk_sys_i,
	input wire logic              resetn_i,
	// bus handshakes
	input wire logic              s_axi_awvalid_i,
	input wire logic              s_axi_awready_o,
	input wire logic              s_axi_wvalid_i,
	input wire logic              s_axi_wready_o,
	input wire logic [1:0]        s_axi_bresp_o,
	input wire logic              s_axi_bvalid_o,
	input wire logic              s_axi_bready_i,
	input wire logic              s_axi_arvalid_i,
	input wire logic              s_axi_arready_o,
	input wire logic [31:0]       s_axi_rdata_o,
	input wire logic              s_axi_rvalid_o,
	input wire logic              s_axi_rready_i,
	// pins and converter
	input wire logic              prog_pin_five_o,
	input wire logic              prog_pin_six_o,
	input wire wut_pkg::wut_dac_t dac_o,
	input wire logic              dac_load_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------------------------
	// bus answers stand until taken
	// ----------------------------------------------------------
	a_write_resp_hold: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped early");
	a_read_data_hold: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped early");
	a_read_gate: assert property (
		s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer pending");
	a_write_gate: assert property (
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	a_write_answer: assert property (
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
		s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	a_read_answer: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	// ----------------------------------------------------------
	// pins and converter codes
	// ----------------------------------------------------------
	a_start_pulse: assert property (
		$rose(prog_pin_six_o) |=> !prog_pin_six_o)
		else $error("start pulse too wide");
	a_strobe_with_load: assert property (
		dac_load_o |-> prog_pin_five_o)
		else $error("load without update strobe");
	a_code_steady: assert property (
		!dac_load_o |-> $stable(dac_o.code))
		else $error("code changed without load");
endmodule

// ---- dv/wut_conv_model.sv ----
// converter-side model: records every code the converters take
`timescale 1ns/1ps
module wut_conv_model (
	// clock
	input wire logic              clk_sys_i,
	// converter side
	input wire logic              dac_load_o,
	input wire wut_pkg::wut_dac_t dac_o
);
	logic [31:0] codes[$];

	// one code per load pulse, both channels in one word
	always @(posedge clk_sys_i)
		if (dac_load_o === 1'b1)
			codes.push_back(dac_o.code);
endmodule

// ---- dv/wut_core_bench.sv ----
// self-checking bench for the waveform update timing block
`timescale 1ns/1ps
module wut_core_bench;
	logic              clk_sys_i;
	logic              resetn_i;
	logic [7:0]        s_axi_awaddr_i;
	logic [7:0]        s_axi_araddr_i;
	logic [31:0]       s_axi_wdata_i;
	logic [3:0]        s_axi_wstrb_i;
	logic              s_axi_awvalid_i;
	logic              s_axi_wvalid_i;
	logic              s_axi_bready_i;
	logic              s_axi_arvalid_i;
	logic              s_axi_rready_i;
	logic              s_axi_awready_o;
	logic              s_axi_wready_o;
	logic              s_axi_bvalid_o;
	logic              s_axi_arready_o;
	logic              s_axi_rvalid_o;
	logic [1:0]        s_axi_bresp_o;
	logic [1:0]        s_axi_rresp_o;
	logic [31:0]       s_axi_rdata_o;
	wire logic         prog_pin_five_i;
	wire logic         prog_pin_six_i;
	logic              prog_pin_five_o;
	logic              prog_pin_six_o;
	logic              prog_pin_five_oe_n_o;
	logic              prog_pin_six_oe_n_o;
	logic              generation_hold_trigger_i;
	logic              dac_load_o;
	logic              irq_o;
	wut_pkg::wut_dac_t dac_o;
	logic              ext_five;
	logic              ext_six;
	logic [31:0]       rd_v;
	logic [1:0]        rsp;
	int                fails;
	int                checks;
	int                five_falls;

	// pin level: the block wins while it drives, else the outside
	assign prog_pin_five_i = prog_pin_five_oe_n_o ? ext_five : prog_pin_five_o;
	assign prog_pin_six_i  = prog_pin_six_oe_n_o ? ext_six : prog_pin_six_o;

	wut_core       i_wut_core (.*);
	wut_conv_model i_wut_conv_model (.*);

	// falling edges of the update strobe, counted out of reset only
	always @(negedge prog_pin_five_o)
		if (resetn_i === 1'b1)
			five_falls++;

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [31:0] smp(input int i);
		return 32'h8000_0100 + 32'h0001_0001 * i;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic dd;
		ad = 1;
		dd = 1;
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		// address and data may be taken on different edges
		while (ad | dd) begin
			@(posedge clk_sys_i);
			if (ad && s_axi_awready_o) begin
				ad = 0;
				s_axi_awvalid_i <= 1'b0;
			end
			if (dd && s_axi_wready_o) begin
				dd = 0;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge clk_sys_i); while (s_axi_bvalid_o !== 1'b1);
		rsp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
		rd_v = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		rd(a);
		chk(rd_v & m, e);
	endtask

	// bounded wait for the converter model to see n loads
	task automatic wait_loads(input int n);
		repeat (200)
			if (i_wut_conv_model.codes.size() < n) @(posedge clk_sys_i);
	endtask

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------
	initial begin
		clk_sys_i = 0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fails++;
		test_done;
	end

	initial begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
		s_axi_awaddr_i = 8'h00;
		s_axi_araddr_i = 8'h00;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hF;
		{ext_five, ext_six, generation_hold_trigger_i} = 3'h0;
		fails = 0;
		checks = 0;
		resetn_i = 0;
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		// reset values and an unmapped place
		rchk(wut_pkg::OFS_CTRL, 32'hFF, 32'h0);
		rchk(wut_pkg::OFS_DIV, 32'hFFFF, 32'(wut_pkg::DIV_RESET));
		rchk(wut_pkg::OFS_IRQ_STAT, 32'h7, 32'h0);
		chk({prog_pin_five_oe_n_o, prog_pin_six_oe_n_o}, 32'h3);
		rd(8'h40);
		chk(rsp, wut_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(rsp, wut_pkg::RESP_SLVERR);
		// finite run started by command, one word left over
		wr(wut_pkg::OFS_DIV, 32'h2);
		wr(wut_pkg::OFS_COUNT, 32'h3);
		wr(wut_pkg::OFS_IRQ_EN, 32'h2);
		for (int i = 0; i < 4; i++) wr(wut_pkg::OFS_DATA, smp(i));
		rchk(wut_pkg::OFS_STATUS, 32'h1F, 32'h4);
		wr(wut_pkg::OFS_CTRL, 32'h0D);
		chk({prog_pin_five_oe_n_o, prog_pin_six_oe_n_o}, 32'h0);
		wr(wut_pkg::OFS_CMD, 32'h1);
		wait_loads(3);
		repeat (30) @(posedge clk_sys_i);
		chk(i_wut_conv_model.codes.size(), 32'h3);
		chk(five_falls, 32'h3);
		for (int i = 0; i < 3; i++)
			chk(i_wut_conv_model.codes[i], smp(i));
		rchk(wut_pkg::OFS_DONE_CNT, 32'hFFFF_FFFF, 32'h3);
		rchk(wut_pkg::OFS_STATUS, 32'hDF, 32'h1);
		rchk(wut_pkg::OFS_IRQ_STAT, 32'h7, 32'h6);
		chk(irq_o, 32'h1);
		wr(wut_pkg::OFS_IRQ_CLR, 32'h7);
		@(posedge clk_sys_i);
		chk(irq_o, 32'h0);
		// empty queue in a continuous run: underflow, masked first
		wr(wut_pkg::OFS_CMD, 32'h4);
		wr(wut_pkg::OFS_CTRL, 32'h0);
		wr(wut_pkg::OFS_CMD, 32'h1);
		repeat (40) @(posedge clk_sys_i);
		rchk(wut_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
		chk(i_wut_conv_model.codes.size(), 32'h3);
		chk(irq_o, 32'h0);
		wr(wut_pkg::OFS_IRQ_EN, 32'h1);
		@(posedge clk_sys_i);
		chk(irq_o, 32'h1);
		wr(wut_pkg::OFS_CMD, 32'h2);
		wr(wut_pkg::OFS_IRQ_CLR, 32'h7);
		@(posedge clk_sys_i);
		chk(irq_o, 32'h0);
		rchk(wut_pkg::OFS_IRQ_STAT, 32'h7, 32'h0);
		// pin-six trigger, outside reference, hold level active
		wr(wut_pkg::OFS_COUNT, 32'h2);
		wr(wut_pkg::OFS_CTRL, 32'h71);
		wr(wut_pkg::OFS_DATA, smp(8));
		wr(wut_pkg::OFS_DATA, smp(9));
		generation_hold_trigger_i <= 1'b1;
		wr(wut_pkg::OFS_CMD, 32'h1);
		repeat (20) @(posedge clk_sys_i);
		rchk(wut_pkg::OFS_STATUS, 32'h40, 32'h40);
		ext_six <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		ext_six <= 1'b0;
		repeat (20) @(posedge clk_sys_i);
		chk(i_wut_conv_model.codes.size(), 32'h3);
		generation_hold_trigger_i <= 1'b0;
		wait_loads(5);
		chk(i_wut_conv_model.codes.size(), 32'h5);
		chk(i_wut_conv_model.codes[4], smp(9));
		chk(dac_o.ref_ext, 32'h1);
		// regenerate from a queue not at index zero, hold level inverted
		wr(wut_pkg::OFS_CTRL, 32'hC2);
		wr(wut_pkg::OFS_DATA, smp(10));
		wr(wut_pkg::OFS_DATA, smp(11));
		wr(wut_pkg::OFS_CMD, 32'h1);
		repeat (20) @(posedge clk_sys_i);
		chk(i_wut_conv_model.codes.size(), 32'h5);
		generation_hold_trigger_i <= 1'b1;
		wait_loads(9);
		wr(wut_pkg::OFS_CMD, 32'h2);
		for (int i = 5; i < 9; i++)
			chk(i_wut_conv_model.codes[i], smp(11 - i % 2));
		rchk(wut_pkg::OFS_IRQ_STAT, 32'h1, 32'h0);
		test_done;
	end
endmodule

bind wut_core wut_core_monitor i_wut_core_monitor (.*);
